// file: core/pvdc_pkg.sv
// Constants for the second-stage loop oscillator and divider register slice.
package pvdc_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_VCO_LOOP_CONTROL          = 16'h0203;
  localparam logic [15:0] ADDR_OSCILLATOR_OUTPUT_DIVIDER = 16'h0204;
  localparam logic [15:0] ADDR_LOOP_FILTER_SETTINGS      = 16'h0205;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_VCO_LOOP_CONTROL = 8'h00;
  localparam logic [7:0] RST_OUTPUT_DIVIDER   = 8'h00;
  localparam logic [7:0] RST_LOOP_FILTER      = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------------
  localparam int BIT_REF_PATH_EN   = 4;
  localparam int BIT_CAL_DIV_RESET = 3;
  localparam int BIT_REF_VALID_OVR = 2;
  localparam int BIT_FORCE_MID     = 1;
  localparam int BIT_MANUAL_CAL    = 0;
  localparam int BIT_PFD_REF_EDGE  = 5;
  localparam int BIT_PFD_FB_EDGE   = 4;
  localparam int BIT_DIV_PD        = 3;
  localparam int DIV_SEL_MSB       = 2;
  localparam int POLE_MSB          = 7;
  localparam int POLE_LSB          = 6;
  localparam int ZERO_MSB          = 5;
  localparam int ZERO_LSB          = 3;
  localparam logic [7:0] MASK_VCO_LOOP_CONTROL = 8'h1f;
  localparam logic [7:0] MASK_OUTPUT_DIVIDER   = 8'h3f;
  localparam logic [7:0] MASK_LOOP_FILTER      = 8'hf8;

  // ----------------------------------------------------------------------
  // Divider select codes and ratios
  // ----------------------------------------------------------------------
  localparam logic [2:0] DIV_CODE_3 = 3'h3;
  localparam logic [2:0] DIV_CODE_4 = 3'h4;
  localparam logic [2:0] DIV_CODE_5 = 3'h5;
  localparam logic [2:0] DIV_RATIO_3 = 3'h3;
  localparam logic [2:0] DIV_RATIO_4 = 3'h4;
  localparam logic [2:0] DIV_RATIO_5 = 3'h5;

  // ----------------------------------------------------------------------
  // Resistor values in ohms
  // ----------------------------------------------------------------------
  localparam logic [11:0] POLE_OHM_0 = 12'h384;
  localparam logic [11:0] POLE_OHM_1 = 12'h1c2;
  localparam logic [11:0] POLE_OHM_2 = 12'h12c;
  localparam logic [11:0] POLE_OHM_3 = 12'h0e1;
  localparam logic [11:0] ZERO_OHM_0 = 12'hcb2;
  localparam logic [11:0] ZERO_OHM_1 = 12'habe;
  localparam logic [11:0] ZERO_OHM_2 = 12'h8ca;
  localparam logic [11:0] ZERO_OHM_3 = 12'h834;
endpackage

// file: core/pvdc_regs.sv
// Oscillator control, output divider and loop filter register slice.
//
// Functional notes
// - Bit 4 enables doubler and input divider path.
// - Bit 3 holds calibration dividers in reset.
// - Bit 2 forces reference valid, else first loop.
// - Bit 1 forces tuning voltage to midscale.
// - Bit 0 starts calibration; software clears it.
// - Divider bit 3 powers down output divider.
// - Divider codes 011/100/101 divide by 3/4/5.
// - Calibration reset clears two-bit and six-bit words.
`timescale 1ns/1ps
`default_nettype none

module pvdc_regs
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        first_stage_vco_ok,
  input  wire logic [1:0]  cal_a_word,
  input  wire logic [5:0]  cal_b_word,
  output var  logic        ref_path_en,
  output var  logic        cal_div_reset,
  output var  logic        ref_valid,
  output var  logic        vco_force_mid,
  output var  logic        cal_run,
  output var  logic        pfd_ref_falling,
  output var  logic        pfd_fb_falling,
  output var  logic        out_div_pd,
  output var  logic [2:0]  out_div_ratio,
  output var  logic        out_div_code_ok,
  output var  logic [11:0] second_pole_resistor,
  output var  logic [11:0] loop_zero_resistor,
  output var  logic [1:0]  cal_a_div,
  output var  logic [5:0]  cal_b_div
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic [11:0] pole_ohms(input logic [1:0] code);
    logic [11:0] v;
    v = pvdc_pkg::POLE_OHM_0;
    unique case (code)
      2'h0: v = pvdc_pkg::POLE_OHM_0;
      2'h1: v = pvdc_pkg::POLE_OHM_1;
      2'h2: v = pvdc_pkg::POLE_OHM_2;
      2'h3: v = pvdc_pkg::POLE_OHM_3;
    endcase
    return v;
  endfunction

  // Codes above 011 belong to the upper zero-resistor range, handled
  // elsewhere; this slice reports 0 ohms for them.
  function automatic logic [11:0] zero_ohms(input logic [2:0] code);
    logic [11:0] v;
    v = 12'h000;
    case (code)
      3'h0:    v = pvdc_pkg::ZERO_OHM_0;
      3'h1:    v = pvdc_pkg::ZERO_OHM_1;
      3'h2:    v = pvdc_pkg::ZERO_OHM_2;
      3'h3:    v = pvdc_pkg::ZERO_OHM_3;
      default: v = 12'h000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0]  vco_loop_control_q;
  logic [7:0]  oscillator_output_divider_q;
  logic [7:0]  loop_filter_settings_q;
  logic [7:0]  rdata_q;
  logic [2:0]  ratio_q;
  logic        code_ok_q;
  logic [11:0] pole_q;
  logic [11:0] zero_q;
  logic        vco_ok_meta_q;
  logic        vco_ok_sync_q;
  logic        ref_valid_q;
  logic [1:0]  cal_a_q;
  logic [5:0]  cal_b_q;

  wire sel_vco  = (reg_addr == pvdc_pkg::ADDR_VCO_LOOP_CONTROL);
  wire sel_div  = (reg_addr == pvdc_pkg::ADDR_OSCILLATOR_OUTPUT_DIVIDER);
  wire sel_filt = (reg_addr == pvdc_pkg::ADDR_LOOP_FILTER_SETTINGS);
  wire wr_vco   = reg_wr && sel_vco;
  wire wr_div   = reg_wr && sel_div;
  wire wr_filt  = reg_wr && sel_filt;

  wire [2:0] div_sel = reg_wdata[pvdc_pkg::DIV_SEL_MSB:0];
  wire [1:0] pole_sel = reg_wdata[pvdc_pkg::POLE_MSB:pvdc_pkg::POLE_LSB];
  wire [2:0] zero_sel = reg_wdata[pvdc_pkg::ZERO_MSB:pvdc_pkg::ZERO_LSB];

  // Unsupported divider codes give ratio 0 and drop the ok flag.
  wire       div_ok_d    = (div_sel == pvdc_pkg::DIV_CODE_3) ||
                           (div_sel == pvdc_pkg::DIV_CODE_4) ||
                           (div_sel == pvdc_pkg::DIV_CODE_5);
  wire [2:0] div_ratio_d =
    (div_sel == pvdc_pkg::DIV_CODE_3) ? pvdc_pkg::DIV_RATIO_3 :
    (div_sel == pvdc_pkg::DIV_CODE_4) ? pvdc_pkg::DIV_RATIO_4 :
    (div_sel == pvdc_pkg::DIV_CODE_5) ? pvdc_pkg::DIV_RATIO_5 : 3'h0;

  wire [7:0] rdata_d =
    sel_vco  ? vco_loop_control_q          :
    sel_div  ? oscillator_output_divider_q :
    sel_filt ? loop_filter_settings_q      : 8'h00;

  // Reserved bits are masked on write so they always read back as zero.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vco_loop_control_q          <= pvdc_pkg::RST_VCO_LOOP_CONTROL;
      oscillator_output_divider_q <= pvdc_pkg::RST_OUTPUT_DIVIDER;
      loop_filter_settings_q      <= pvdc_pkg::RST_LOOP_FILTER;
      rdata_q                     <= 8'h00;
    end
    else
    begin
      if (wr_vco)
        vco_loop_control_q <= reg_wdata & pvdc_pkg::MASK_VCO_LOOP_CONTROL;
      if (wr_div)
        oscillator_output_divider_q <= reg_wdata & pvdc_pkg::MASK_OUTPUT_DIVIDER;
      if (wr_filt)
        loop_filter_settings_q <= reg_wdata & pvdc_pkg::MASK_LOOP_FILTER;
      if (reg_rd)
        rdata_q <= rdata_d;
    end
  end

  // Decoded values are captured with the write so they move in step with
  // the stored fields.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ratio_q   <= 3'h0;
      code_ok_q <= 1'b0;
      pole_q    <= pvdc_pkg::POLE_OHM_0;
      zero_q    <= pvdc_pkg::ZERO_OHM_0;
    end
    else
    begin
      if (wr_div)
      begin
        ratio_q   <= div_ratio_d;
        code_ok_q <= div_ok_d;
      end
      if (wr_filt)
      begin
        pole_q <= pole_ohms(pole_sel);
        zero_q <= zero_ohms(zero_sel);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reference valid and calibration dividers
  // ----------------------------------------------------------------------
  // The first loop's indicator comes from another block's timing, so it is
  // synchronised before use.
  wire ref_valid_d = vco_loop_control_q[pvdc_pkg::BIT_REF_VALID_OVR] ||
                     vco_ok_sync_q;
  wire cal_rst     = vco_loop_control_q[pvdc_pkg::BIT_CAL_DIV_RESET];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vco_ok_meta_q <= 1'b0;
      vco_ok_sync_q <= 1'b0;
      ref_valid_q   <= 1'b0;
      cal_a_q       <= 2'h0;
      cal_b_q       <= 6'h00;
    end
    else
    begin
      vco_ok_meta_q <= first_stage_vco_ok;
      vco_ok_sync_q <= vco_ok_meta_q;
      ref_valid_q   <= ref_valid_d;
      cal_a_q       <= cal_rst ? 2'h0 : cal_a_word;
      cal_b_q       <= cal_rst ? 6'h00 : cal_b_word;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata            = rdata_q;
  assign ref_path_en          = vco_loop_control_q[pvdc_pkg::BIT_REF_PATH_EN];
  assign cal_div_reset        = cal_rst;
  assign ref_valid            = ref_valid_q;
  assign vco_force_mid        = vco_loop_control_q[pvdc_pkg::BIT_FORCE_MID];
  // Level, not a pulse: a second run needs a write of 0 first.
  assign cal_run              = vco_loop_control_q[pvdc_pkg::BIT_MANUAL_CAL];
  assign pfd_ref_falling      = oscillator_output_divider_q[pvdc_pkg::BIT_PFD_REF_EDGE];
  assign pfd_fb_falling       = oscillator_output_divider_q[pvdc_pkg::BIT_PFD_FB_EDGE];
  assign out_div_pd           = oscillator_output_divider_q[pvdc_pkg::BIT_DIV_PD];
  assign out_div_ratio        = ratio_q;
  assign out_div_code_ok      = code_ok_q;
  assign second_pole_resistor = pole_q;
  assign loop_zero_resistor   = zero_q;
  assign cal_a_div            = cal_a_q;
  assign cal_b_div            = cal_b_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_ref_path;
    @(posedge ref_clk) disable iff (!arst_n)
    wr_vco |=> (ref_path_en == $past(reg_wdata[4]));
  endproperty
  a_ref_path: assert property (p_ref_path) else $error("path enable wrong");

  property p_cal_div_reset;
    @(posedge ref_clk) disable iff (!arst_n)
    cal_div_reset |=> (cal_a_div == 2'h0) && (cal_b_div == 6'h00);
  endproperty
  a_cal_div_reset: assert property (p_cal_div_reset) else $error("cal dividers not held");

  property p_cal_words;
    @(posedge ref_clk) disable iff (!arst_n)
    !cal_div_reset |=> (cal_a_div == $past(cal_a_word)) && (cal_b_div == $past(cal_b_word));
  endproperty
  a_cal_words: assert property (p_cal_words) else $error("cal words not passed");

  property p_ref_valid_ovr;
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_vco && reg_wdata[2]) |=> ##1 ref_valid;
  endproperty
  a_ref_valid_ovr: assert property (p_ref_valid_ovr) else $error("override ignored");

  property p_ref_valid_follow;
    @(posedge ref_clk) disable iff (!arst_n)
    (!vco_loop_control_q[2] && !first_stage_vco_ok)[*3] |=> !ref_valid;
  endproperty
  a_ref_valid_follow: assert property (p_ref_valid_follow) else $error("valid without source");

  property p_force_mid;
    @(posedge ref_clk) disable iff (!arst_n)
    wr_vco |=> (vco_force_mid == $past(reg_wdata[1]));
  endproperty
  a_force_mid: assert property (p_force_mid) else $error("midscale wrong");

  property p_cal_hold;
    @(posedge ref_clk) disable iff (!arst_n)
    (cal_run && !wr_vco) |=> cal_run;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("cal bit self-cleared");

  property p_div_pd;
    @(posedge ref_clk) disable iff (!arst_n)
    wr_div |=> (out_div_pd == $past(reg_wdata[3]));
  endproperty
  a_div_pd: assert property (p_div_pd) else $error("power-down wrong");

  property p_div_four;
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_div && reg_wdata[2:0] == 3'h4) |=> (out_div_ratio == 3'h4) && out_div_code_ok;
  endproperty
  a_div_four: assert property (p_div_four) else $error("divide by 4 wrong");

  property p_pole;
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_filt && reg_wdata[7:6] == 2'h1) |=> (second_pole_resistor == 12'h1c2);
  endproperty
  a_pole: assert property (p_pole) else $error("pole resistor wrong");

  property p_zero;
    @(posedge ref_clk) disable iff (!arst_n)
    (wr_filt && reg_wdata[5:3] == 3'h3) |=> (loop_zero_resistor == 12'h834);
  endproperty
  a_zero: assert property (p_zero) else $error("zero resistor wrong");

  c_cal_start: cover property (@(posedge ref_clk) disable iff (!arst_n)
    !cal_run ##1 cal_run);
  c_div_five: cover property (@(posedge ref_clk) disable iff (!arst_n)
    out_div_ratio == 3'h5);
  c_ovr_valid: cover property (@(posedge ref_clk) disable iff (!arst_n)
    vco_loop_control_q[2] && !vco_ok_sync_q && ref_valid);

endmodule

`default_nettype wire

// file: dv/pvdc_regs_bench.sv
// Self-checking bench for the oscillator, divider and loop filter registers.
`timescale 1ns/1ps
`default_nettype none

module pvdc_regs_bench;
  localparam logic [15:0] A_VCO = pvdc_pkg::ADDR_VCO_LOOP_CONTROL;
  localparam logic [15:0] A_DIV = pvdc_pkg::ADDR_OSCILLATOR_OUTPUT_DIVIDER;
  localparam logic [15:0] A_FLT = pvdc_pkg::ADDR_LOOP_FILTER_SETTINGS;
  logic        ref_clk, arst_n, reg_wr, reg_rd, first_stage_vco_ok;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [1:0]  cal_a_word, cal_a_div;
  logic [5:0]  cal_b_word, cal_b_div;
  logic        ref_path_en, cal_div_reset, ref_valid, vco_force_mid, cal_run;
  logic        pfd_ref_falling, pfd_fb_falling, out_div_pd, out_div_code_ok;
  logic [2:0]  out_div_ratio;
  logic [11:0] second_pole_resistor, loop_zero_resistor;
  int          n_fail, total_checks, m_vco, m_div, m_flt, seed_val, dc;
  int          pole_ohm [4] = '{900, 450, 300, 225};
  int          zero_ohm [8] = '{3250, 2750, 2250, 2100, 0, 0, 0, 0};

  pvdc_regs dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .first_stage_vco_ok(first_stage_vco_ok),
    .cal_a_word(cal_a_word), .cal_b_word(cal_b_word),
    .ref_path_en(ref_path_en), .cal_div_reset(cal_div_reset),
    .ref_valid(ref_valid), .vco_force_mid(vco_force_mid), .cal_run(cal_run),
    .pfd_ref_falling(pfd_ref_falling), .pfd_fb_falling(pfd_fb_falling),
    .out_div_pd(out_div_pd), .out_div_ratio(out_div_ratio),
    .out_div_code_ok(out_div_code_ok),
    .second_pole_resistor(second_pole_resistor),
    .loop_zero_resistor(loop_zero_resistor), .cal_a_div(cal_a_div),
    .cal_b_div(cal_b_div));

  always #4 ref_clk = ~ref_clk;

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // The model follows the register only for mapped addresses.
  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    if (a == A_VCO) m_vco = d & pvdc_pkg::MASK_VCO_LOOP_CONTROL;
    if (a == A_DIV) m_div = d & pvdc_pkg::MASK_OUTPUT_DIVIDER;
    if (a == A_FLT) m_flt = d & pvdc_pkg::MASK_LOOP_FILTER;
  endtask

  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic check_all;
    logic [7:0] rd;
    int         code;
    code = m_div & 7;
    // Valid flag and calibration words register one edge after the field.
    @(posedge ref_clk);
    #1;
    chk("ref_path_en", 32'(ref_path_en), (m_vco >> 4) & 1);
    chk("cal_div_reset", 32'(cal_div_reset), (m_vco >> 3) & 1);
    chk("ref_valid", 32'(ref_valid), (m_vco >> 2) & 1);
    chk("vco_force_mid", 32'(vco_force_mid), (m_vco >> 1) & 1);
    chk("cal_run", 32'(cal_run), m_vco & 1);
    chk("pfd", 32'({pfd_ref_falling, pfd_fb_falling}), (m_div >> 4) & 3);
    chk("out_div_pd", 32'(out_div_pd), (m_div >> 3) & 1);
    chk("ratio", 32'(out_div_ratio), (code > 2 && code < 6) ? code : 0);
    chk("code_ok", 32'(out_div_code_ok), code > 2 && code < 6);
    chk("pole", 32'(second_pole_resistor), pole_ohm[m_flt >> 6]);
    chk("zero", 32'(loop_zero_resistor), zero_ohm[(m_flt >> 3) & 7]);
    chk("cal_a", 32'(cal_a_div), m_vco[3] ? 0 : 32'(cal_a_word));
    chk("cal_b", 32'(cal_b_div), m_vco[3] ? 0 : 32'(cal_b_word));
    reg_read(A_VCO, rd);
    chk("rd_vco", 32'(rd), m_vco);
    reg_read(A_DIV, rd);
    chk("rd_div", 32'(rd), m_div);
    reg_read(A_FLT, rd);
    chk("rd_flt", 32'(rd), m_flt);
    reg_read(16'h0206, rd);
    chk("rd_unmapped", 32'(rd), 0);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {reg_wr, reg_rd, first_stage_vco_ok} = 3'h0;
    {reg_addr, reg_wdata, cal_a_word, cal_b_word} = '0;
    {n_fail, total_checks, m_vco, m_div, m_flt} = '0;
    seed_val = $urandom(32'h8e79);
    repeat (5) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    check_all();
    $display("test reset done");
    // Every divider code, every resistor code, each control bit.
    for (int c = 0; c < 8; c++)
    begin
      reg_write(A_DIV, 8'(c | (c << 3)) | 8'hc0);
      reg_write(A_FLT, 8'(((c & 3) << 6) | (c << 3) | 7));
      check_all();
    end
    for (int b = 0; b < 5; b++)
    begin
      reg_write(A_VCO, 8'(1 << b) | 8'he0);
      check_all();
    end
    $display("test codes done");
    // Calibration start stays set until software clears it.
    reg_write(A_VCO, 8'h01);
    repeat (40) @(posedge ref_clk);
    check_all();
    reg_write(A_VCO, 8'h00);
    check_all();
    $display("test calibration done");
    // Indicator reaches the valid flag after three edges.
    @(posedge ref_clk);
    #1;
    first_stage_vco_ok = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ref_valid_early", 32'(ref_valid), 0);
    @(posedge ref_clk);
    #1;
    chk("ref_valid_ind", 32'(ref_valid), 1);
    first_stage_vco_ok = 1'b0;
    repeat (4) @(posedge ref_clk);
    reg_write(A_VCO, 8'h04);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ref_valid_ovr", 32'(ref_valid), 1);
    $display("test ref valid done");
    // A read in the same cycle as a write returns the old value.
    @(posedge ref_clk);
    #1;
    reg_addr = A_FLT;
    reg_wdata = 8'h48;
    {reg_wr, reg_rd} = 2'h3;
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_rd} = 2'h0;
    chk("rd_old", 32'(reg_rdata), m_flt);
    m_flt = 8'h48;
    check_all();
    $display("test same cycle done");
    // Random traffic, an unmapped address among the targets.
    for (int i = 0; i < 24; i++)
    begin
      dc = $urandom_range(6, 3);
      cal_a_word = 2'($urandom);
      cal_b_word = 6'($urandom);
      reg_write(16'h0200 | 16'(dc), 8'($urandom));
      check_all();
    end
    $display("test random done");
    // Reset in mid-run clears every field at once.
    @(posedge ref_clk);
    #1;
    arst_n = 1'b0;
    #2;
    chk("pole_rst", 32'(second_pole_resistor), 900);
    chk("zero_rst", 32'(loop_zero_resistor), 3250);
    {m_vco, m_div, m_flt} = '0;
    @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    check_all();
    $display("test mid reset done");
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    stop_test();
  end
endmodule

`default_nettype wire
